// file: hw/fsrs_map.vh
// Purpose: constants of the fail-safe reset supervisor
// Assumes: 20 MHz clock, 50 ns period
// Notes:   times in ns, counts derived by rounding as documented per use
`ifndef FSRS_MAP_VH
`define FSRS_MAP_VH

// ==================================================
// register offsets
`define FSRS_ADDR_W        4
`define FSRS_REG_CTRL      4'h0
`define FSRS_REG_STATUS    4'h1
`define FSRS_REG_IRQ_STAT  4'h2
`define FSRS_REG_IRQ_MASK  4'h3
`define FSRS_REG_COUNTS    4'h4
`define FSRS_REG_CFG       4'h5

// ==================================================
// ctrl fields
`define FSRS_CTRL_SPI_OK   0
`define FSRS_CTRL_CLR_FS   1
`define FSRS_CTRL_WD_OFF   2
`define FSRS_CTRL_OT_EN    3
// cfg fields
`define FSRS_CFG_SINGLE    0
`define FSRS_CFG_FC_LIM_LO 4
`define FSRS_CFG_RESET     8'h31

// ==================================================
// irq bits
`define FSRS_IRQ_W         6
`define FSRS_IRQ_VIO       0
`define FSRS_IRQ_WD        1
`define FSRS_IRQ_CLAMP     2
`define FSRS_IRQ_TMO       3
`define FSRS_IRQ_FC_OVF    4
`define FSRS_IRQ_FS        5

// ==================================================
// timing
`define FSRS_CLK_NS        50
`define FSRS_T_FLTR_NS     1000
`define FSRS_T_D_RST_NS    10000
`define FSRS_T_TO_RST_NS   100000
`define FSRS_T_REL_NS      5000
`define FSRS_T_WD_NS       200000
`define FSRS_FLTR_CYC      ((`FSRS_T_FLTR_NS + `FSRS_CLK_NS - 1) / `FSRS_CLK_NS)
`define FSRS_D_RST_CYC     ((`FSRS_T_D_RST_NS + `FSRS_CLK_NS - 1) / `FSRS_CLK_NS)
`define FSRS_TO_RST_CYC    (`FSRS_T_TO_RST_NS / `FSRS_CLK_NS)
`define FSRS_REL_CYC       (`FSRS_T_REL_NS / `FSRS_CLK_NS)
`define FSRS_WD_CYC        (`FSRS_T_WD_NS / `FSRS_CLK_NS)
`define FSRS_WATCHDOG_FAIL_COUNTER_MAX      3'h7

`endif

// file: hw/fsrs_supervisor.v
// Purpose: fail-safe reset supervisor: reset line, watchdog, limp-home
// Assumes: host serves the watchdog by pulse; pins synchronised here
// Notes:   vio faults arrive as filtered flags from the supply monitor
//
// Operation
// - config picks single-violation or continued-violation entry into fail-safe
// - violations: vio fault, watchdog, reset clamp, reset timeout, counter overflow
// - idle state holds reset low awaiting system reset mode
// - init drives reset low and starts reset timeout timer
// - timing state keeps reset low for hold duration
// - on completion reset line released, released state entered
// - software development mode keeps the watchdog off
// - bad trigger or overflow restarts watchdog, increments fail counter
// - fail-safe entry enables limp-home low, clears cycle counter
// - standby with pending interrupt clears watchdog standby disable
// - overtemp drop to listen-only keeps overtemp detection on
// - four prioritised exits evaluated before all other transitions
// - direct normal start also enters software development mode
// - valid serial message then reset loop goes to standby
// - no valid serial message then reset loop returns to normal
// - interrupt pending when any status bit set, shown on receive line
`include "fsrs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fsrs_supervisor
(
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata,
  input  wire        rst_line_in,
  output wire        rst_line_out,
  output wire        rst_line_oe,
  output wire        limp_home_output_n,
  input  wire        vio_nok,
  input  wire        direct_normal_start,
  input  wire        sys_reset_mode,
  input  wire        sys_standby_mode,
  input  wire        sys_normal_mode,
  input  wire        overtemp,
  input  wire        wd_trigger,
  input  wire        wd_trigger_bad,
  output wire        rxd_int_n,
  output wire        irq,
  output wire        go_standby,
  output wire        go_normal,
  output wire        go_listen_only,
  output wire        ot_detect_en,
  output wire        wd_running
);

// ==================================================
// pin synchronisers
reg [1:0] rsti_sync_ff;
reg [1:0] vio_sync_ff;
wire      rsti_s = rsti_sync_ff[1];
wire      vio_s  = vio_sync_ff[1];

always @(posedge clk)
begin
  if (rst)
  begin
    rsti_sync_ff <= 2'h0;
    vio_sync_ff  <= 2'h0;
  end
  else if (ce)
  begin
    rsti_sync_ff <= {rsti_sync_ff[0], rst_line_in};
    vio_sync_ff  <= {vio_sync_ff[0], vio_nok};
  end
end

// ==================================================
// states
localparam [9:0] S_IDLE = 10'h001;
localparam [9:0] S_INIT = 10'h002;
localparam [9:0] S_TIM  = 10'h004;
localparam [9:0] S_REL  = 10'h008;
localparam [9:0] S_SDM  = 10'h010;
localparam [9:0] S_ACT  = 10'h020;
localparam [9:0] S_WRES = 10'h040;
localparam [9:0] S_WRF  = 10'h080;
localparam [9:0] S_FS   = 10'h100;
localparam [9:0] S_INCR = 10'h200;

reg [9:0]  state_ff;
reg [9:0]  nxt_state;
reg [12:0] tmo_ff;
reg [12:0] nxt_tmo;
reg [8:0]  hold_ff;
reg [8:0]  nxt_hold;
reg [4:0]  flt_hi_ff;
reg [4:0]  flt_lo_ff;
reg [15:0] wd_ff;
reg [15:0] nxt_wd;
reg [2:0]  watchdog_fail_counter_ff;
reg [2:0]  nxt_watchdog_fail_counter;
reg [3:0]  failsafe_cycle_counter_ff;
reg [3:0]  nxt_failsafe_cycle_counter;
reg        sdm_ff;
reg        spi_ok_ff;
reg        wd_off_ff;
reg        ot_en_ff;
reg        lo_ot_ff;
reg        loop_seen_ff;
reg [7:0]  cfg_ff;
reg [5:0]  mask_ff;
reg [5:0]  stat_ff;
reg [5:0]  ev;
reg        srm_q_ff;

wire rstn_high  = (flt_hi_ff == `FSRS_FLTR_CYC);
wire ext_trig   = (flt_lo_ff == `FSRS_FLTR_CYC);
wire single_cfg = cfg_ff[`FSRS_CFG_SINGLE];
wire [2:0] fc_lim = cfg_ff[6:4];
wire in_reset   = state_ff[0] | state_ff[1] | state_ff[2];
wire wr_ctrl    = wr_stb & (addr == `FSRS_REG_CTRL);
wire exit_ok    = ~state_ff[8] & ~state_ff[9];
wire srm_rise   = sys_reset_mode & ~srm_q_ff;

// ==================================================
// reset-line filters
always @(posedge clk)
begin
  if (rst)
  begin
    flt_hi_ff <= 5'h00;
    flt_lo_ff <= 5'h00;
  end
  else if (ce)
  begin
    if (!rsti_s)
      flt_hi_ff <= 5'h00;
    else if (!rstn_high)
      flt_hi_ff <= flt_hi_ff + 5'h01;
    if (rsti_s)
      flt_lo_ff <= 5'h00;
    else if (!ext_trig)
      flt_lo_ff <= flt_lo_ff + 5'h01;
  end
end

// ==================================================
// fail-safe state machine
always @*
begin
  nxt_state = state_ff;
  nxt_tmo   = tmo_ff;
  nxt_hold  = hold_ff;
  nxt_wd    = wd_ff;
  nxt_watchdog_fail_counter  = watchdog_fail_counter_ff;
  nxt_failsafe_cycle_counter  = failsafe_cycle_counter_ff;
  ev        = 6'h00;
  // incr is a one-cycle step: a held fault must not pin it; rel has its own check
  if (vio_s && exit_ok)
  begin
    ev[`FSRS_IRQ_VIO] = 1'b1;
    nxt_state = single_cfg ? S_FS : S_INCR;
  end
  else if (ext_trig && exit_ok && !in_reset && !state_ff[3])
  begin
    ev[`FSRS_IRQ_CLAMP] = 1'b1;
    nxt_state = single_cfg ? S_FS : S_INCR;
  end
  else if (in_reset && !state_ff[0] && tmo_ff == `FSRS_TO_RST_CYC)
  begin
    ev[`FSRS_IRQ_TMO] = 1'b1;
    nxt_state = single_cfg ? S_FS : S_INCR;
  end
  else if (state_ff[3] && hold_ff == `FSRS_REL_CYC && !rstn_high)
  begin
    ev[`FSRS_IRQ_CLAMP] = 1'b1;
    nxt_state = single_cfg ? S_FS : S_INCR;
  end
  else
  begin
    case (state_ff)
      S_IDLE:
      begin
        if (sys_reset_mode)
        begin
          nxt_state = S_INIT;
          nxt_tmo   = 13'h0000;
        end
      end
      S_INIT:
      begin
        nxt_tmo   = tmo_ff + 13'h0001;
        nxt_hold  = 9'h000;
        nxt_state = S_TIM;
      end
      S_TIM:
      begin
        nxt_tmo = tmo_ff + 13'h0001;
        if (hold_ff == `FSRS_D_RST_CYC)
        begin
          nxt_state = S_REL;
          nxt_hold  = 9'h000;
        end
        else
          nxt_hold = hold_ff + 9'h001;
      end
      S_REL:
      begin
        if (rstn_high)
        begin
          nxt_wd    = 16'h0000;
          nxt_state = sdm_ff ? S_SDM : S_WRES;
        end
        else if (hold_ff != `FSRS_REL_CYC)
          nxt_hold = hold_ff + 9'h001;
      end
      S_SDM:
      begin
        if (srm_rise)
          nxt_state = S_IDLE;
        else if (!sdm_ff)
          nxt_state = S_WRES;
      end
      S_WRES:
      begin
        nxt_wd    = 16'h0000;
        nxt_state = S_ACT;
      end
      S_ACT:
      begin
        if (srm_rise)
          nxt_state = S_IDLE;
        else if (sdm_ff)
          nxt_state = S_SDM;
        else if (wd_trigger_bad || (wd_running && wd_ff == `FSRS_WD_CYC))
          nxt_state = S_WRF;
        else if (wd_trigger)
          nxt_state = S_WRES;
        else if (wd_running)
          nxt_wd = wd_ff + 16'h0001;
      end
      S_WRF:
      begin
        ev[`FSRS_IRQ_WD] = 1'b1;
        nxt_wd   = 16'h0000;
        nxt_watchdog_fail_counter = watchdog_fail_counter_ff + 3'h1;
        if (single_cfg || watchdog_fail_counter_ff == `FSRS_WATCHDOG_FAIL_COUNTER_MAX - 3'h1)
          nxt_state = S_INCR;
        else
          nxt_state = S_ACT;
      end
      S_INCR:
      begin
        nxt_watchdog_fail_counter = 3'h0;
        if (failsafe_cycle_counter_ff[2:0] >= fc_lim || single_cfg)
        begin
          ev[`FSRS_IRQ_FC_OVF] = ~single_cfg;
          nxt_state = S_FS;
        end
        else
        begin
          nxt_failsafe_cycle_counter  = failsafe_cycle_counter_ff + 4'h1;
          nxt_state = S_IDLE;
        end
      end
      S_FS:
      begin
        nxt_failsafe_cycle_counter = 4'h0;
        ev[`FSRS_IRQ_FS] = ~state_ff[8];
      end
      default:
        nxt_state = S_IDLE;
    endcase
  end
  if (nxt_state == S_FS && !state_ff[8])
  begin
    ev[`FSRS_IRQ_FS] = 1'b1;
    nxt_failsafe_cycle_counter = 4'h0;
  end
end

always @(posedge clk)
begin
  if (rst)
  begin
    state_ff                  <= S_IDLE;
    tmo_ff                    <= 13'h0000;
    hold_ff                   <= 9'h000;
    wd_ff                     <= 16'h0000;
    watchdog_fail_counter_ff                   <= 3'h0;
    failsafe_cycle_counter_ff <= 4'h0;
  end
  else if (ce)
  begin
    state_ff                  <= (state_ff[8] && wr_ctrl && wdata[`FSRS_CTRL_CLR_FS]) ? S_IDLE : nxt_state;
    tmo_ff                    <= nxt_tmo;
    hold_ff                   <= nxt_hold;
    wd_ff                     <= nxt_wd;
    watchdog_fail_counter_ff                   <= nxt_watchdog_fail_counter;
    failsafe_cycle_counter_ff <= nxt_failsafe_cycle_counter;
  end
end

// ==================================================
// mode flags and software control
wire irq_pend = |stat_ff;

always @(posedge clk)
begin
  if (rst)
  begin
    sdm_ff       <= 1'b0;
    spi_ok_ff    <= 1'b0;
    wd_off_ff    <= 1'b0;
    ot_en_ff     <= 1'b1;
    lo_ot_ff     <= 1'b0;
    loop_seen_ff <= 1'b0;
    srm_q_ff     <= 1'b0;
    cfg_ff       <= `FSRS_CFG_RESET;
    mask_ff      <= 6'h00;
    stat_ff      <= 6'h00;
  end
  else if (ce)
  begin
    if (direct_normal_start)
      sdm_ff <= 1'b1;
    if (direct_normal_start)
      spi_ok_ff <= 1'b0;
    else if (wr_ctrl && wdata[`FSRS_CTRL_SPI_OK])
      spi_ok_ff <= 1'b1;
    if (sys_standby_mode && irq_pend)
      wd_off_ff <= 1'b0;
    else if (wr_ctrl)
      wd_off_ff <= wdata[`FSRS_CTRL_WD_OFF];
    if (sys_normal_mode && overtemp)
      lo_ot_ff <= 1'b1;
    else if (!overtemp)
      lo_ot_ff <= 1'b0;
    if (wr_ctrl)
      ot_en_ff <= wdata[`FSRS_CTRL_OT_EN];
    loop_seen_ff <= sdm_ff & state_ff[3] & rstn_high;
    srm_q_ff     <= sys_reset_mode;
    if (wr_stb && addr == `FSRS_REG_CFG)
      cfg_ff <= wdata[7:0];
    if (wr_stb && addr == `FSRS_REG_IRQ_MASK)
      mask_ff <= wdata[5:0];
    // set wins over the write-one clear
    if (wr_stb && addr == `FSRS_REG_IRQ_STAT)
      stat_ff <= (stat_ff & ~wdata[5:0]) | ev;
    else
      stat_ff <= stat_ff | ev;
  end
end

// ==================================================
// outputs
assign rst_line_out       = 1'b0;
assign rst_line_oe        = in_reset;
assign limp_home_output_n = ~state_ff[8];
assign rxd_int_n          = ~irq_pend;
assign irq                = |(stat_ff & mask_ff);
assign go_standby         = loop_seen_ff & spi_ok_ff;
assign go_normal          = loop_seen_ff & ~spi_ok_ff;
assign go_listen_only     = lo_ot_ff;
assign ot_detect_en       = ot_en_ff | lo_ot_ff;
assign wd_running         = ~sdm_ff & (state_ff[5] | state_ff[6] | state_ff[7]) & (~sys_standby_mode | ~wd_off_ff);

// ==================================================
// register read, data one cycle later
always @(posedge clk)
begin
  if (rst)
    rdata <= 32'h00000000;
  else if (ce)
  begin
    rdata <= 32'h00000000;
    if (rd_stb)
    begin
      case (addr)
        `FSRS_REG_CTRL:     rdata <= {28'h0000000, ot_en_ff, wd_off_ff, 1'b0, spi_ok_ff};
        `FSRS_REG_STATUS:   rdata <= {20'h00000, sdm_ff, ~limp_home_output_n, state_ff};
        `FSRS_REG_IRQ_STAT: rdata <= {26'h0000000, stat_ff};
        `FSRS_REG_IRQ_MASK: rdata <= {26'h0000000, mask_ff};
        `FSRS_REG_COUNTS:   rdata <= {25'h0000000, watchdog_fail_counter_ff, failsafe_cycle_counter_ff};
        `FSRS_REG_CFG:      rdata <= {24'h000000, cfg_ff};
        default:            rdata <= 32'h00000000;
      endcase
    end
  end
end

endmodule // fsrs_supervisor
`default_nettype wire

// file: tb/fsrs_chk.sv
// Purpose: port assertions of the fail-safe reset supervisor
// Assumes: single clock, rst synchronous active high
// Notes:   bound below the module
`include "fsrs_map.vh"
`timescale 1ns/1ps
`default_nettype none
module fsrs_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic        rst_line_oe,
  input wire logic        rst_line_out,
  input wire logic        limp_home_output_n,
  input wire logic        direct_normal_start,
  input wire logic        rxd_int_n,
  input wire logic        irq,
  input wire logic        go_standby,
  input wire logic        go_normal,
  input wire logic        wd_running
);
  logic [15:0] hi_cnt_ff;
  logic        sdm_ff;
  logic        sdm_q_ff;
  // ==================================================
  // helpers: low-drive length, dev mode seen
  always_ff @(posedge clk)
  begin
    hi_cnt_ff <= (rst || !rst_line_oe) ? 16'h0 : hi_cnt_ff + 16'h1;
    sdm_ff <= rst ? 1'b0 : (sdm_ff | direct_normal_start);
    sdm_q_ff <= rst ? 1'b0 : sdm_ff;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==================================================
  // assertions
  a_idle_after_rst: assert property ($past(rst) |-> rst_line_oe && limp_home_output_n)
    else $error("reset line not held after reset");
  a_line_low: assert property (rst_line_out == 1'b0)
    else $error("reset line driven high");
  a_hold_min: assert property ($fell(rst_line_oe) && limp_home_output_n |-> hi_cnt_ff >= `FSRS_D_RST_CYC)
    else $error("reset released too early");
  a_sdm_wd_off: assert property (sdm_q_ff |-> !wd_running)
    else $error("watchdog runs in dev mode");
  a_irq_pend: assert property (irq |-> !rxd_int_n)
    else $error("irq without pending flag");
  a_go_excl: assert property (!(go_standby && go_normal))
    else $error("two exits at once");
  a_go_pulse: assert property (go_standby || go_normal |=> !go_standby && !go_normal)
    else $error("exit pulse too long");
  a_rd_quiet: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data outside slot");
  c_fs: cover property ($fell(limp_home_output_n));
  c_std: cover property (go_standby);
  c_nrm: cover property (go_normal);
endmodule // fsrs_chk
bind fsrs_supervisor fsrs_chk chk_u (.clk(clk), .rst(rst), .rd_stb(rd_stb), .rdata(rdata),
  .rst_line_oe(rst_line_oe), .rst_line_out(rst_line_out), .limp_home_output_n(limp_home_output_n),
  .direct_normal_start(direct_normal_start), .rxd_int_n(rxd_int_n), .irq(irq),
  .go_standby(go_standby), .go_normal(go_normal), .wd_running(wd_running));
`default_nettype wire

// file: tb/fsrs_host.sv
// Purpose: host model: serves watchdog, loads the reset line
// Assumes: reset line pulled up, open drain on both sides
// Notes:   bad service only when the bench asks for it
`timescale 1ns/1ps
`default_nettype none
module fsrs_host
#(parameter int PER = 1000)
(
  input  wire logic clk,
  input  wire logic rst_line_oe,
  input  wire logic wd_running,
  input  wire logic clamp,
  input  wire logic bad,
  output wire logic rst_line_in,
  output var  logic wd_trigger,
  output var  logic wd_trigger_bad
);
  int   cnt;
  logic bad_q;
  // ==================================================
  // wired-and line, pull-up wins when nobody drives
  assign rst_line_in = !(rst_line_oe || clamp);
  initial
  begin
    cnt = 0;
    bad_q = 1'b0;
    wd_trigger = 1'b0;
    wd_trigger_bad = 1'b0;
  end
  always @(posedge clk)
  begin
    bad_q <= bad;
    wd_trigger_bad <= bad && !bad_q && wd_running;
    cnt <= (wd_running && cnt < PER) ? cnt + 1 : 0;
    wd_trigger <= wd_running && cnt == PER && !bad;
  end
endmodule // fsrs_host
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench of the fail-safe reset supervisor
// Assumes: 50 ns clock, host model on the reset line
// Notes:   seed fixed, random register traffic mixed in
`include "fsrs_map.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst, wr_stb, rd_stb, dns, srm, clamp, bad;
  logic        sby, nrm, ot, vio;
  logic [3:0]  addr, a;
  logic [31:0] wdata, rdata, d;
  wire         rst_line_in, rst_line_out, rst_line_oe, limp_n, wd_trigger, wd_trigger_bad;
  wire         rxd_int_n, irq, go_standby, go_normal, wd_running, lo, ote;
  int          mismatches, tests_run, n;
  fsrs_supervisor dut_u (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .rst_line_in(rst_line_in), .rst_line_out(rst_line_out),
    .rst_line_oe(rst_line_oe), .limp_home_output_n(limp_n), .vio_nok(vio), .direct_normal_start(dns),
    .sys_reset_mode(srm), .sys_standby_mode(sby), .sys_normal_mode(nrm), .overtemp(ot),
    .wd_trigger(wd_trigger), .wd_trigger_bad(wd_trigger_bad), .rxd_int_n(rxd_int_n), .irq(irq),
    .go_standby(go_standby), .go_normal(go_normal), .go_listen_only(lo), .ot_detect_en(ote),
    .wd_running(wd_running));
  fsrs_host host_u (.clk(clk), .rst_line_oe(rst_line_oe), .wd_running(wd_running), .clamp(clamp),
    .bad(bad), .rst_line_in(rst_line_in), .wd_trigger(wd_trigger), .wd_trigger_bad(wd_trigger_bad));
  // ==================================================
  // helpers
  function automatic logic [31:0] exp_cnt(input logic [3:0] failsafe_cycle_counter, input logic [2:0] watchdog_fail_counter);
    return {25'h0, watchdog_fail_counter, failsafe_cycle_counter};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge clk);
    addr <= ad;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
  endtask
  task automatic wait_on(input int which);
    for (n = 0; n < 30000; n++)
    begin
      if ((which == 0 && !rst_line_oe) || (which == 1 && wd_running) || (which == 2 && !limp_n)
          || (which == 3 && limp_n) || (which == 4 && go_normal) || (which == 5 && go_standby))
        break;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==================================================
  // clock, watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #(50 * 20000);
    mismatches++;
    wrap_up();
  end
  // ==================================================
  // main sequence
  initial
  begin
    {rst, wr_stb, rd_stb, dns, srm, clamp, bad, addr, wdata} = {1'b1, 42'h0};
    {sby, nrm, ot, vio} = 4'h0;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(94));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(4'h1);
    chk(rdata, 32'h1);
    rd(4'h5);
    chk(rdata, `FSRS_CFG_RESET);
    // continued-violation mode, fail limit 3
    wr(4'h5, 32'h30);
    repeat (8)
    begin
      a = 4'h6 + 4'($urandom % 10);
      wr(a, $urandom);
      rd(a);
      chk(rdata, 32'h0);
      d = $urandom;
      wr(4'h3, d);
      rd(4'h3);
      chk(rdata, d & 32'h3F);
    end
    // reset process, hold then release
    @(posedge clk);
    srm <= 1'b1;
    wait_on(0);
    chk({31'h0, n >= `FSRS_D_RST_CYC}, 32'h1);
    wait_on(1);
    chk({31'h0, wd_running}, 32'h1);
    srm <= 1'b0;
    wr(4'h3, 32'h0);
    repeat (2)
    begin
      @(posedge clk);
      bad <= 1'b1;
      repeat (4) @(posedge clk);
      bad <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rd(4'h4);
    chk(rdata, exp_cnt(4'h0, 3'h2));
    chk({30'h0, irq, rxd_int_n}, 32'h0);
    wr(4'h3, 32'h2);
    rd(4'h2);
    chk({30'h0, irq, rdata[1]}, 32'h3);
    wr(4'h2, 32'h3F);
    @(posedge clk);
    #1;
    chk({30'h0, irq, rxd_int_n}, 32'h1);
    // standby with wd off, then a pending event re-arms the watchdog
    wr(4'h0, 32'hC);
    sby <= 1'b1;
    @(posedge clk);
    #1;
    chk({31'h0, wd_running}, 32'h0);
    vio <= 1'b1;
    @(posedge clk);
    vio <= 1'b0;
    repeat (6) @(posedge clk);
    rd(4'h0);
    chk(rdata & 32'h4, 32'h0);
    chk({31'h0, rxd_int_n}, 32'h0);
    rd(4'h4);
    chk(rdata, exp_cnt(4'h1, 3'h0));
    // overtemp drop keeps detection on even when disabled
    sby <= 1'b0;
    nrm <= 1'b1;
    ot <= 1'b1;
    wr(4'h2, 32'h3F);
    wr(4'h0, 32'h0);
    @(posedge clk);
    #1;
    chk({30'h0, lo, ote}, 32'h3);
    ot <= 1'b0;
    @(posedge clk);
    #1;
    chk({30'h0, lo, ote}, 32'h0);
    nrm <= 1'b0;
    wr(4'h0, 32'h8);
    // clamped reset line ends in fail-safe
    srm <= 1'b1;
    clamp <= 1'b1;
    wait_on(2);
    chk({31'h0, limp_n}, 32'h0);
    rd(4'h4);
    chk(rdata & 32'hF, 32'h0);
    rd(4'h1);
    chk(rdata & 32'h500, 32'h500);
    clamp <= 1'b0;
    srm <= 1'b0;
    wr(4'h0, 32'h2);
    wait_on(3);
    chk({31'h0, limp_n}, 32'h1);
    // single-violation mode: one bad service goes straight to fail-safe
    wr(4'h5, 32'h31);
    srm <= 1'b1;
    wait_on(1);
    srm <= 1'b0;
    bad <= 1'b1;
    wait_on(2);
    bad <= 1'b0;
    chk({31'h0, limp_n}, 32'h0);
    rd(4'h4);
    chk(rdata, exp_cnt(4'h0, 3'h0));
    // direct normal start and reset loops
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    dns <= 1'b1;
    @(posedge clk);
    dns <= 1'b0;
    rd(4'h1);
    chk({31'h0, rdata[11]}, 32'h1);
    chk({31'h0, wd_running}, 32'h0);
    srm <= 1'b1;
    wait_on(4);
    chk({31'h0, go_normal}, 32'h1);
    srm <= 1'b0;
    wr(4'h0, 32'h1);
    @(posedge clk);
    srm <= 1'b1;
    wait_on(5);
    chk({31'h0, go_standby}, 32'h1);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
